// ==== design/trig_map.vh ====
// constants for the acquisition trigger logic
// Notes on behaviour
// (R1) four selectable trigger sources
// (R2) button forces trigger once acquisition armed
// (R3) digital and analog comparator drive path directly
// (R4) digital condition fires trigger when ready
// (R5) conditions while not ready are discarded
// (R6) no indication of discarded conditions
// (R7) analog input compared to programmable level
// (R8) rising analog needs prior dip below band
// (R9) per-channel validity evaluated each scan first
// (R10) combiner selectable OR or AND
// (R11) instantaneous channel follows condition each scan
// (R12) latched channel holds valid until acquisition re-armed
// (R13) OR triggers at first valid scan
// (R14) level init valid whenever threshold met
// (R15) edge init needs invalid state first
// (R16) eight channel types from three bits
// (R17) slope selects above or below threshold
// (R18) samples from one 16-bit sixteen-channel converter
// (R19) aggregate throughput at most 200 kS/s
// (R20) single-ended low terminal is channel n+8
// (R21) four input ranges per channel
// (R22) latched validity cleared only on re-arm
// (R23) non-latched edge channel drops below band
// (R24) thresholds held as signed 16-bit codes
// (R25) trigger is one-cycle pulse, then not ready
`ifndef TRIG_MAP_VH
`define TRIG_MAP_VH
// register indices (word address = index)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_CH_TYPE 4'h2
`define REG_CH_MASK 4'h3
`define REG_CH_SEL 4'h4
`define REG_CH_THR 4'h5
`define REG_CH_HYS 4'h6
`define REG_CH_RANGE 4'h7
`define REG_ARM 4'h8
`define REG_EXT_ANALOG_TRIG_IN 4'h9
// control fields
`define CTRL_SRC_LSB 0
`define CTRL_CFG_OK 2
`define CTRL_AND 3
`define CTRL_DPOL 4
// sources
`define SRC_DIG 2'h0
`define SRC_ANA 2'h1
`define SRC_MULTI 2'h2
`define SRC_PAT 2'h3
// channel type bits: slope, duration, initialization
`define TYPE_BELOW 0
`define TYPE_LATCH 1
`define TYPE_EDGE 2
// 200 kS/s at 125 MHz: minimum cycles between conversions
`define SAMPLE_RATE_SPS 200000
`define CLOCK_HZ 125000000
`define CONV_CYCLES (`CLOCK_HZ / `SAMPLE_RATE_SPS)
`define RANGE_RESET 2'h0
`endif

// ==== design/acquisition_trigger_logic.v ====
// acquisition trigger logic: source select, comparators, multichannel combiner
`timescale 1ns/1ps
`include "trig_map.vh"
module acquisition_trigger_logic #(
  parameter NCH = 16,
  parameter PAT_W = 16
) (
  input wire clock,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire ext_digital_trig_in,
  input wire ana_cmp_above,
  input wire ana_cmp_below_band,
  input wire manual_trigger_button,
  input wire [PAT_W-1:0] pattern_in,
  input wire [PAT_W-1:0] pattern_value,
  input wire [PAT_W-1:0] pattern_mask,
  input wire sample_valid,
  input wire [3:0] sample_chan,
  input wire [15:0] sample_data,
  input wire scan_end,
  input wire acq_done,
  output reg trigger_pulse,
  output wire ready,
  output reg armed_out,
  output reg [NCH-1:0] chan_valid_out,
  output reg sample_overrun
);
  // one-hot trigger states
  localparam S_IDLE = 3'b001;
  localparam S_ARMED = 3'b010;
  localparam S_BUSY = 3'b100;
  // spacing limit, cut to the counter width on purpose; 625 needs ten bits
  localparam integer CONV_INT = `CONV_CYCLES;
  localparam [9:0] CONV_MIN = CONV_INT[9:0];

  // trigger sequencing, configuration and per-channel memories
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [7:0] ctrl_ff; // source, cfg ok, and/or, digital polarity
  reg [NCH-1:0] type_below_ff; // slope per channel [R17]
  reg [NCH-1:0] type_latch_ff; // duration per channel
  reg [NCH-1:0] type_edge_ff; // initialization per channel
  reg [NCH-1:0] mask_ff; // channels taking part
  reg [3:0] sel_ff; // channel being configured
  reg signed [15:0] thr_mem [0:NCH-1]; // thresholds [R24]
  reg signed [15:0] hys_mem [0:NCH-1]; // far side of hysteresis band [R24]
  reg [1:0] range_mem [0:NCH-1]; // input range code, four settings [R21]
  reg [NCH-1:0] valid_ff; // per-channel validity
  reg [NCH-1:0] primed_ff; // edge channel saw invalid state
  reg [NCH-1:0] scan_valid_ff; // validity gathered within current scan
  reg dig_prev_ff; // previous digital trigger level
  reg ana_primed_ff; // analog input has been below band
  reg btn_prev_ff;
  reg pat_prev_ff;
  reg [9:0] conv_cnt_ff; // spacing between conversions
  reg multi_hit_ff; // combined result latched at scan end
  integer i;

  // control register fields
  wire [1:0] src = ctrl_ff[`CTRL_SRC_LSB +: 2];
  wire cfg_ok = ctrl_ff[`CTRL_CFG_OK];
  wire and_mode = ctrl_ff[`CTRL_AND];
  wire dig_pol = ctrl_ff[`CTRL_DPOL];

  // ready only when configured and armed, never while finishing [R5]
  assign ready = state_ff[1] & cfg_ok;

  // per-channel condition on one sample, with level and band compare
  // a sample exactly on the threshold counts as reaching it
  function cond_met;
    input signed [15:0] smp;
    input signed [15:0] thr;
    input below;
    begin
      if (below) begin
        cond_met = (smp <= thr);
      end else begin
        cond_met = (smp >= thr);
      end
    end
  endfunction

  // strictly beyond the hysteresis bound; a sample on the bound is still inside
  function past_band;
    input signed [15:0] smp;
    input signed [15:0] hys;
    input below;
    begin
      if (below) begin
        past_band = (smp > hys);
      end else begin
        past_band = (smp < hys);
      end
    end
  endfunction

  // digital edge on the trigger pin; polarity picks rising or falling [R4]
  wire dig_event = (ext_digital_trig_in != dig_prev_ff) &&
                   (ext_digital_trig_in == ~dig_pol);
  // comparator fires only after the input was below the band [R8]
  wire ana_event = ana_cmp_above & ana_primed_ff; // [R7]
  // button press edge
  wire btn_event = manual_trigger_button & ~btn_prev_ff;
  // pattern match edge
  wire pat_match = ((pattern_in ^ pattern_value) & pattern_mask) == {PAT_W{1'b0}};
  wire pat_event = pat_match & ~pat_prev_ff;

  // chosen source; digital and comparator go straight in, no sample path [R1] [R3]
  reg src_event;
  always @* begin
    src_event = 1'b0;
    case (src)
      `SRC_DIG: src_event = dig_event;
      `SRC_ANA: src_event = ana_event;
      `SRC_MULTI: src_event = multi_hit_ff;
      `SRC_PAT: src_event = pat_event;
      default: src_event = 1'b0;
    endcase
  end

  // the trigger is taken only when ready, else dropped with no trace [R5] [R6]
  wire fire = ready & (src_event | btn_event); // [R2]

  // state sequencing
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (wr && addr == `REG_ARM && wdata[0]) begin
          nxt_state = S_ARMED;
        end
      end
      S_ARMED: begin
        if (fire) begin
          nxt_state = S_BUSY; // not ready until re-armed [R25]
        end
      end
      S_BUSY: begin
        if (acq_done) begin
          nxt_state = S_IDLE;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // state, pulse and edge history
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      trigger_pulse <= 1'b0;
      armed_out <= 1'b0;
      dig_prev_ff <= 1'b0;
      btn_prev_ff <= 1'b0;
      pat_prev_ff <= 1'b0;
      ana_primed_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      trigger_pulse <= fire; // single-cycle pulse [R25]
      armed_out <= nxt_state[1];
      // edge history; a pin resting high at reset gives one false rising edge
      dig_prev_ff <= ext_digital_trig_in;
      btn_prev_ff <= manual_trigger_button;
      pat_prev_ff <= pat_match;
      // band memory: set below band, spent at the next rise above level, whether or not the trigger fires [R8]
      if (ana_cmp_below_band) begin
        ana_primed_ff <= 1'b1;
      end else if (ana_event) begin
        ana_primed_ff <= 1'b0;
      end
    end
  end

  // register writes
  // unmapped indices are ignored; the arm index is taken by the state logic
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= 8'h00;
      type_below_ff <= {NCH{1'b0}};
      type_latch_ff <= {NCH{1'b0}};
      type_edge_ff <= {NCH{1'b0}};
      mask_ff <= {NCH{1'b0}};
      sel_ff <= 4'h0;
      for (i = 0; i < NCH; i = i + 1) begin
        thr_mem[i] <= 16'sh0000;
        hys_mem[i] <= 16'sh0000;
        range_mem[i] <= `RANGE_RESET;
      end
    end else if (wr) begin
      if (addr == `REG_CTRL) begin
        ctrl_ff <= wdata[7:0];
      end else if (addr == `REG_CH_TYPE) begin
        // eight types: slope, duration, initialization bits [R16]
        type_below_ff[sel_ff] <= wdata[`TYPE_BELOW];
        type_latch_ff[sel_ff] <= wdata[`TYPE_LATCH];
        type_edge_ff[sel_ff] <= wdata[`TYPE_EDGE];
      end else if (addr == `REG_CH_MASK) begin
        mask_ff <= wdata[NCH-1:0];
      end else if (addr == `REG_CH_SEL) begin
        sel_ff <= wdata[3:0];
      end else if (addr == `REG_CH_THR) begin
        thr_mem[sel_ff] <= wdata[15:0];
      end else if (addr == `REG_CH_HYS) begin
        hys_mem[sel_ff] <= wdata[15:0];
      end else if (addr == `REG_CH_RANGE) begin
        range_mem[sel_ff] <= wdata[1:0];
      end
    end
  end

  // multichannel evaluation, one sample at a time within a scan [R9] [R18]
  // channels 8-15 are the low terminals of pairs 0-7 in single-ended use, so one
  // 4-bit index covers both wirings and each channel keeps its own state [R20]
  wire signed [15:0] smp = sample_data;
  wire c_below = type_below_ff[sample_chan];
  wire c_met = cond_met(smp, thr_mem[sample_chan], c_below);
  wire c_band = past_band(smp, hys_mem[sample_chan], c_below);
  wire c_valid = valid_ff[sample_chan];
  // re-arm is the idle-to-armed step; it wipes all multichannel history
  wire rearm = (state_ff[0] && nxt_state[1]);
  // next validity and priming of the channel carried by this sample
  reg n_valid;
  reg n_primed;
  always @* begin
    n_valid = c_valid;
    n_primed = primed_ff[sample_chan];
    if (type_edge_ff[sample_chan]) begin
      // edge: needs invalid state (beyond band) first [R15]
      if (c_band) begin
        n_primed = 1'b1;
        if (!type_latch_ff[sample_chan]) begin
          n_valid = 1'b0; // drop out below band [R23]
        end
      end else if (c_met && primed_ff[sample_chan]) begin
        n_valid = 1'b1;
        n_primed = 1'b0;
      end
    end else begin
      // level: valid whenever met, even at start [R14]
      if (c_met) begin
        n_valid = 1'b1;
      end else if (!type_latch_ff[sample_chan]) begin
        n_valid = 1'b0; // instantaneous follows condition [R11]
      end
    end
    if (type_latch_ff[sample_chan] && c_valid) begin
      n_valid = 1'b1; // latched holds [R12]
    end
  end

  // combiner input for a scan that just closed
  // an empty mask never satisfies the AND combine
  wire [NCH-1:0] scan_now = scan_valid_ff;
  wire or_hit = |(scan_now & mask_ff);
  wire and_hit = (mask_ff != {NCH{1'b0}}) && ((scan_now & mask_ff) == mask_ff);

  // validity state and scan combine
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      valid_ff <= {NCH{1'b0}};
      primed_ff <= {NCH{1'b0}};
      scan_valid_ff <= {NCH{1'b0}};
      multi_hit_ff <= 1'b0;
      chan_valid_out <= {NCH{1'b0}};
    end else if (rearm) begin
      // latched validity cleared only when re-armed [R22]
      valid_ff <= {NCH{1'b0}};
      primed_ff <= {NCH{1'b0}};
      scan_valid_ff <= {NCH{1'b0}};
      multi_hit_ff <= 1'b0;
      chan_valid_out <= {NCH{1'b0}};
    end else begin
      // the combined hit is a one-cycle strobe
      multi_hit_ff <= 1'b0;
      if (sample_valid) begin
        valid_ff[sample_chan] <= n_valid;
        primed_ff[sample_chan] <= n_primed;
        scan_valid_ff[sample_chan] <= n_valid;
      end
      if (scan_end) begin
        // AND waits for all, OR takes the first valid scan [R10] [R13]
        multi_hit_ff <= and_mode ? and_hit : or_hit;
        chan_valid_out <= scan_valid_ff;
      end
    end
  end

  // conversion spacing check: flags samples faster than 200 kS/s [R19]
  // the counter resets saturated so the first sample after reset is never an overrun
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt_ff <= 10'h3FF;
      sample_overrun <= 1'b0;
    end else begin
      if (sample_valid) begin
        conv_cnt_ff <= 10'h000; // a new conversion restarts the spacing count
      end else if (conv_cnt_ff != 10'h3FF) begin
        conv_cnt_ff <= conv_cnt_ff + 10'h001; // saturate so long gaps never wrap
      end
      // a close sample in the clearing read cycle wins, so no overrun is lost
      if (sample_valid && (conv_cnt_ff < CONV_MIN - 10'h001)) begin
        sample_overrun <= 1'b1;
      end else if (rd && addr == `REG_STATUS) begin
        sample_overrun <= 1'b0; // cleared by reading status
      end
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  // status packs state, ready, combined hit and overrun
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      if (addr == `REG_CTRL) begin
        rdata <= {24'h000000, ctrl_ff};
      end else if (addr == `REG_STATUS) begin
        rdata <= {26'h0000000, sample_overrun, multi_hit_ff, ready, state_ff};
      end else if (addr == `REG_CH_TYPE) begin
        rdata <= {29'h00000000, type_edge_ff[sel_ff], type_latch_ff[sel_ff],
                  type_below_ff[sel_ff]};
      end else if (addr == `REG_CH_MASK) begin
        rdata <= {{(32-NCH){1'b0}}, mask_ff};
      end else if (addr == `REG_CH_SEL) begin
        rdata <= {28'h0000000, sel_ff};
      end else if (addr == `REG_CH_THR) begin
        rdata <= {16'h0000, thr_mem[sel_ff]};
      end else if (addr == `REG_CH_HYS) begin
        rdata <= {16'h0000, hys_mem[sel_ff]};
      end else if (addr == `REG_CH_RANGE) begin
        rdata <= {30'h00000000, range_mem[sel_ff]};
      end else if (addr == `REG_EXT_ANALOG_TRIG_IN) begin
        rdata <= {{(32-NCH){1'b0}}, valid_ff};
      end else begin
        rdata <= 32'h00000000;
      end
    end
  end
endmodule // acquisition_trigger_logic

// ==== testbench/trig_monitor.sv ====
// port-level assertions for the acquisition trigger logic
`timescale 1ns/1ps
`include "trig_map.vh"
module trig_monitor (
  input wire clock,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire ext_digital_trig_in,
  input wire ana_cmp_above,
  input wire manual_trigger_button,
  input wire sample_valid,
  input wire scan_end,
  input wire trigger_pulse,
  input wire ready,
  input wire armed_out,
  input wire sample_overrun
);
  reg [4:0] ctrl_ff; // shadow of source select and polarity
  reg btn_ff; // button level one cycle back
  wire btn_rise = manual_trigger_button & ~btn_ff;
  wire [1:0] src = ctrl_ff[1:0];
  // follow software writes so properties know the mode; a write lands one cycle later
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= 5'h00;
      btn_ff <= 1'b0;
    end else begin
      btn_ff <= manual_trigger_button;
      if (wr && addr == `REG_CTRL) ctrl_ff <= wdata[4:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_single; trigger_pulse |=> !trigger_pulse; endproperty
  a_single: assert property (p_single) else $error("trigger pulse too long");
  property p_busy; trigger_pulse |-> !ready && !armed_out; endproperty
  a_busy: assert property (p_busy) else $error("still ready after trigger");
  property p_gated; trigger_pulse |-> $past(ready); endproperty
  a_gated: assert property (p_gated) else $error("trigger while not ready");
  property p_dig; ready && src == `SRC_DIG && (ctrl_ff[4] ? $fell(ext_digital_trig_in)
    : $rose(ext_digital_trig_in)) |=> trigger_pulse; endproperty
  a_dig: assert property (p_dig) else $error("digital edge missed");
  property p_btn; ready && btn_rise |=> trigger_pulse; endproperty
  a_btn: assert property (p_btn) else $error("button did not force trigger");
  property p_ana; ready && src == `SRC_ANA && !ana_cmp_above && !btn_rise |=> !trigger_pulse;
  endproperty
  a_ana: assert property (p_ana) else $error("analog fired below level");
  property p_multi; trigger_pulse && src == `SRC_MULTI && !$past(btn_rise)
    |-> $past(scan_end, 2); endproperty
  a_multi: assert property (p_multi) else $error("multichannel trigger off scan end");
  property p_over; sample_valid ##2 sample_valid |=> sample_overrun; endproperty
  a_over: assert property (p_over) else $error("close samples not flagged");
  c_multi: cover property (trigger_pulse && src == `SRC_MULTI);
  c_btn: cover property (ready && btn_rise);
  c_over: cover property (sample_overrun);
endmodule // trig_monitor
bind acquisition_trigger_logic trig_monitor mon_u (.*);

// ==== testbench/scan_source.sv ====
// stand-in for the converter scan stream at the far side
`timescale 1ns/1ps
module scan_source (
  input wire clock,
  output reg sample_valid = 1'b0,
  output reg [3:0] sample_chan = 4'h0,
  output reg [15:0] sample_data = 16'h0000,
  output reg scan_end = 1'b0
);
  // one 16-bit conversion, then quiet for gap cycles to keep the rate
  task send(input [3:0] ch, input [15:0] d, input integer gap);
    @(posedge clock);
    sample_valid <= 1'b1;
    sample_chan <= ch;
    sample_data <= d;
    @(posedge clock);
    sample_valid <= 1'b0;
    sample_data <= ~d; // stale data must not look valid
    repeat (gap) @(posedge clock);
  endtask
  // end marker a cycle after the last sample's quiet gap, so combining follows all channels
  task close;
    @(posedge clock);
    scan_end <= 1'b1;
    @(posedge clock);
    scan_end <= 1'b0;
  endtask
endmodule // scan_source

// ==== testbench/tb_acquisition_trigger_logic.sv ====
// self-checking bench for the acquisition trigger logic
`timescale 1ns/1ps
`include "trig_map.vh"
module tb_acquisition_trigger_logic;
  reg clock = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, dig = 1'b0;
  reg ana_hi = 1'b0, ana_lo = 1'b0, btn = 1'b0, acq_done = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wdata = 32'h0;
  reg [15:0] hiv, lov;
  reg [15:0] pat = 16'h0000; // input pattern, the only moving pattern signal
  wire [31:0] rdata;
  wire [15:0] chan_valid, sample_data;
  wire [3:0] sample_chan;
  wire trigger_pulse, ready, armed_out, sample_overrun, sample_valid, scan_end;
  integer num_errors = 0, num_checks = 0, seed = 32'h53bb, t, p, k, hit, amp;
  // pattern compare value and mask are fixed; only the input pattern moves
  acquisition_trigger_logic #(.NCH(16), .PAT_W(16)) dut_u (.clock(clock), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_digital_trig_in(dig), .ana_cmp_above(ana_hi), .ana_cmp_below_band(ana_lo),
    .manual_trigger_button(btn), .pattern_in(pat), .pattern_value(16'h00A5),
    .pattern_mask(16'h00FF), .sample_valid(sample_valid), .sample_chan(sample_chan),
    .sample_data(sample_data), .scan_end(scan_end), .acq_done(acq_done),
    .trigger_pulse(trigger_pulse), .ready(ready), .armed_out(armed_out),
    .chan_valid_out(chan_valid), .sample_overrun(sample_overrun));
  scan_source src_u (.clock(clock), .sample_valid(sample_valid), .sample_chan(sample_chan),
    .sample_data(sample_data), .scan_end(scan_end));
  initial begin
    forever #4 clock = ~clock;
  end
  task check(input [31:0] seen, input [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wr_reg(input [3:0] a, input [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // read data appear in the cycle after the strobe and hold until the next read
  task rd_chk(input [3:0] a, input [31:0] m, input [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(rdata & m, e);
  endtask
  // counts one-cycle pulses over a fixed window
  task wait_trig(input integer n, output integer cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (trigger_pulse === 1'b1) cnt = cnt + 1;
    end
  endtask
  task press;
    @(posedge clock);
    btn <= 1'b1;
    wait_trig(3, t);
    check(t, 1);
    @(posedge clock);
    btn <= 1'b0;
  endtask
  task finish_acq;
    @(posedge clock);
    acq_done <= 1'b1;
    @(posedge clock);
    acq_done <= 1'b0;
  endtask
  task scan(input [15:0] a, input [15:0] b, output integer cnt);
    src_u.send(4'h0, a, `CONV_CYCLES);
    src_u.send(4'h1, b, `CONV_CYCLES);
    src_u.close;
    wait_trig(3, cnt);
  endtask
  // model: first scan that fires in OR mode; edge types need the dip scan first
  function integer first_hit(input integer ty);
    first_hit = ty[`TYPE_EDGE] ? 2 : 0;
  endfunction
  initial begin
    #800000;
    num_errors = num_errors + 1;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk(`REG_STATUS, 32'h2F, 32'h1);
    rd_chk(4'hF, 32'hFFFFFFFF, 32'h0);
    wr_reg(`REG_ARM, 32'h1);
    @(posedge clock);
    dig <= 1'b1;
    wait_trig(4, t);
    check(t, 0);
    rd_chk(`REG_STATUS, 32'h2F, 32'h2);
    for (p = 0; p < 2; p = p + 1) begin
      wr_reg(`REG_CTRL, (p << `CTRL_DPOL) | 32'h4);
      wr_reg(`REG_ARM, 32'h1);
      rd_chk(`REG_STATUS, 32'h2F, 32'hA);
      for (k = 0; k < 2; k = k + 1) begin
        @(posedge clock);
        dig <= p[0] ^ k[0]; // wrong edge (no edge at all for falling polarity) first, then the selected one
        wait_trig(3, t);
        check(t, k);
      end
      @(posedge clock);
      dig <= p[0];
      @(posedge clock);
      dig <= ~p[0];
      wait_trig(3, t);
      check(t, 0);
      finish_acq;
      rd_chk(`REG_STATUS, 32'h2F, 32'h1);
    end
    wr_reg(`REG_CTRL, 32'h5);
    wr_reg(`REG_ARM, 32'h1);
    for (k = 0; k < 3; k = k + 1) begin
      @(posedge clock);
      ana_hi <= ~k[0]; // above, dip inside the band, above again
      wait_trig(4, t);
      check(t, 0);
    end
    @(posedge clock);
    ana_hi <= 1'b0;
    ana_lo <= 1'b1;
    @(posedge clock);
    ana_lo <= 1'b0;
    ana_hi <= 1'b1;
    wait_trig(3, t);
    check(t, 1);
    finish_acq;
    wr_reg(`REG_ARM, 32'h1);
    press;
    finish_acq;
    wr_reg(`REG_CTRL, 32'h7);
    wr_reg(`REG_ARM, 32'h1);
    @(posedge clock);
    pat <= 16'h12A5;
    wait_trig(3, t);
    check(t, 1);
    finish_acq;
    wr_reg(`REG_CTRL, 32'h6);
    wr_reg(`REG_CH_MASK, 32'h1);
    wr_reg(`REG_CH_SEL, 32'h0);
    wr_reg(`REG_CH_THR, 32'h64);
    for (p = 0; p < 8; p = p + 1) begin
      wr_reg(`REG_CH_TYPE, p);
      wr_reg(`REG_CH_HYS, p[`TYPE_BELOW] ? 32'h96 : 32'h32);
      wr_reg(`REG_ARM, 32'h1);
      amp = $random(seed) & 32'hFFF;
      hiv = 16'h0097 + amp[15:0];
      lov = 16'h0031 - amp[15:0];
      hit = 3;
      for (k = 0; k < 3; k = k + 1) begin
        scan(((k == 1) ^ p[`TYPE_BELOW]) ? lov : hiv, 16'h0000, t);
        if (t != 0 && hit == 3) hit = k;
      end
      check(hit, first_hit(p));
      finish_acq;
    end
    wr_reg(`REG_CTRL, 32'hE);
    wr_reg(`REG_CH_MASK, 32'h3);
    for (p = 0; p < 2; p = p + 1) begin
      for (k = 0; k < 2; k = k + 1) begin
        wr_reg(`REG_CH_SEL, k);
        wr_reg(`REG_CH_TYPE, p << `TYPE_LATCH);
        wr_reg(`REG_CH_THR, 32'h64);
      end
      wr_reg(`REG_ARM, 32'h1);
      scan(16'h00C8, 16'h0000, t);
      check(t, 0);
      scan(16'h0000, 16'h00C8, t);
      check(t, p);
      check({16'h0000, chan_valid}, p ? 32'h3 : 32'h2);
      rd_chk(`REG_EXT_ANALOG_TRIG_IN, 32'h3, p ? 32'h3 : 32'h2);
      if (p == 0) press;
      finish_acq;
    end
    wr_reg(`REG_CH_SEL, 32'h8);
    wr_reg(`REG_CH_RANGE, 32'h3);
    rd_chk(`REG_CH_RANGE, 32'h3, 32'h3);
    wr_reg(`REG_CH_SEL, 32'h0);
    rd_chk(`REG_CH_RANGE, 32'h3, {30'h00000000, `RANGE_RESET});
    src_u.send(4'h0, 16'h0000, 0);
    src_u.send(4'h0, 16'h0000, 0);
    rd_chk(`REG_STATUS, 32'h20, 32'h20);
    rd_chk(`REG_STATUS, 32'h20, 32'h0);
    tally_and_finish;
  end
endmodule // tb_acquisition_trigger_logic
